// ===== verilog/sfrm_bank.sv
// Special function register bank with reset-cause handling and two-wire read/write split
// Overview of operation
// - Unimplemented bits read back as zero and reset to zero.
// - Port latches load all ones or all zeros from one configuration bit, port 2 in its two implemented bits only.
// - Power control clears low four bits on reset, top two untouched, flags kept.
// - Brownout and power-on flags survive every reset except the supply reset; only that reset, events or software alter them.
// - Power-up sets the power-on flag.
// - Brownout events and power-up set the brownout flag.
// - Watchdog control resets to one of three values chosen by cause and enable.
// - Serial buffer is not cleared by reset.
`timescale 1ns/100ps
module sfrm_bank
	import sfrm_pkg::*;
#(
	parameter logic [7:0] WD_CTRL_AFTER_WD_RESET = 8'h30,
	parameter logic [7:0] WD_CTRL_ENABLED        = 8'h10,
	parameter logic [7:0] WD_CTRL_DISABLED       = 8'h00
) (
	input  wire logic               i_clk_sys,
	input  wire logic               i_reset,
	input  wire logic               i_supply_reset,
	input  wire logic [ADDR_W-1:0]  i_addr,
	input  wire logic [DATA_W-1:0]  i_wdata,
	input  wire logic               i_wr,
	input  wire logic               i_rd,
	output logic      [DATA_W-1:0]  o_rdata,
	input  wire logic               i_brownout_event,
	input  wire logic               i_watchdog_reset_cause,
	input  wire logic               i_watchdog_enabled,
	input  wire logic               i_port_reset_level_select,
	input  wire sfrm_tw_status_type i_tw_status,
	output sfrm_tw_cmd_type         o_tw_cmd,
	output sfrm_port_type           o_port,
	output logic      [7:0]         o_power_control,
	output logic      [7:0]         o_watchdog_control,
	output logic                    o_watchdog_feed,
	output logic                    o_irq
);

	initial begin
		if ((WD_CTRL_AFTER_WD_RESET & ~MASK_WD_CTRL) != 8'h00 ||
			(WD_CTRL_ENABLED & ~MASK_WD_CTRL) != 8'h00 ||
			(WD_CTRL_DISABLED & ~MASK_WD_CTRL) != 8'h00) begin
			$error("sfrm_bank: watchdog reset values use unimplemented bits");
		end
	end

	function automatic logic [7:0] plain_field(input logic [PLAIN_N*8-1:0] table_v,
		input int idx);
		plain_field = table_v[(PLAIN_N-1-idx)*8 +: 8];
	endfunction : plain_field

	// Pin levels
	logic [3:0] pins_sync;
	logic       brownout_s;
	logic       wd_cause_s;
	logic       wd_enabled_s;
	logic       port_level_s;

	sfrm_sync #(
		.WIDTH (4)
	) u_sync (
		.i_clk_sys (i_clk_sys),
		.i_async   ({i_brownout_event, i_watchdog_reset_cause,
			i_watchdog_enabled, i_port_reset_level_select}),
		.o_sync    (pins_sync)
	);

	assign brownout_s   = pins_sync[3];
	assign wd_cause_s   = pins_sync[2];
	assign wd_enabled_s = pins_sync[1];
	assign port_level_s = pins_sync[0];

	// Write and read decode
	logic wr_port0;
	logic wr_port1;
	logic wr_port2;
	logic wr_power;
	logic wr_serbuf;
	logic wr_wd_feed;
	logic wr_wd_ctrl;
	logic wr_tw_cfg;
	logic wr_tw_ctrl;
	logic wr_tw_data;
	logic wr_evt_status;
	logic wr_evt_mask;

	assign wr_port0      = i_wr && (i_addr == ADDR_PORT0);
	assign wr_port1      = i_wr && (i_addr == ADDR_PORT1);
	assign wr_port2      = i_wr && (i_addr == ADDR_PORT2);
	assign wr_power      = i_wr && (i_addr == ADDR_POWER);
	assign wr_serbuf     = i_wr && (i_addr == ADDR_SERBUF);
	assign wr_wd_feed    = i_wr && (i_addr == ADDR_WD_FEED);
	assign wr_wd_ctrl    = i_wr && (i_addr == ADDR_WD_CTRL);
	assign wr_tw_cfg     = i_wr && (i_addr == ADDR_TW_CFG);
	assign wr_tw_ctrl    = i_wr && (i_addr == ADDR_TW_CTRL);
	assign wr_tw_data    = i_wr && (i_addr == ADDR_TW_DATA);
	assign wr_evt_status = i_wr && (i_addr == ADDR_EVT_STATUS);
	assign wr_evt_mask   = i_wr && (i_addr == ADDR_EVT_MASK);

	// Cause-dependent values can't be taken under async reset, so they load one edge later
	logic reset_load_r;

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			reset_load_r <= 1'b1;
		end else begin
			reset_load_r <= 1'b0;
		end
	end

	// Plain registers
	logic [7:0] plain_r [PLAIN_N];

	genvar gi;
	generate
		for (gi = 0; gi < PLAIN_N; gi++) begin : g_plain
			always_ff @(posedge i_clk_sys or posedge i_reset) begin
				if (i_reset) begin
					plain_r[gi] <= plain_field(PLAIN_RESET, gi);
				end else if (i_wr && i_addr == plain_field(PLAIN_ADDR, gi)) begin
					plain_r[gi] <= i_wdata & plain_field(PLAIN_MASK, gi);
				end
			end
		end
	endgenerate

	// Port latches
	logic [7:0] port_level_byte;

	assign port_level_byte = port_level_s ? ONES_BYTE : ZERO_BYTE;

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_port.port0_latch <= ZERO_BYTE;
			o_port.port1_latch <= ZERO_BYTE;
			o_port.port2_latch <= ZERO_BYTE;
		end else if (reset_load_r) begin
			o_port.port0_latch <= port_level_byte;
			o_port.port1_latch <= port_level_byte;
			o_port.port2_latch <= port_level_byte & MASK_PORT2;
		end else begin
			if (wr_port0) begin
				o_port.port0_latch <= i_wdata;
			end
			if (wr_port1) begin
				o_port.port1_latch <= i_wdata;
			end
			if (wr_port2) begin
				o_port.port2_latch <= i_wdata & MASK_PORT2;
			end
		end
	end

	// Mode outputs share the same flops as the plain registers
	assign o_port.port0_mode_a = plain_r[IDX_P0_MODE_A];
	assign o_port.port0_mode_b = plain_r[IDX_P0_MODE_B];
	assign o_port.port1_mode_a = plain_r[IDX_P1_MODE_A];
	assign o_port.port1_mode_b = plain_r[IDX_P1_MODE_B];
	assign o_port.port2_mode_a = plain_r[IDX_P2_MODE_A];
	assign o_port.port2_mode_b = plain_r[IDX_P2_MODE_B];

	// Power control
	logic       brownout_prev_r;
	logic       brownout_rise;
	logic [1:0] pwr_high_r;
	logic       pwr_brownout_r;
	logic       pwr_power_on_r;
	logic [3:0] pwr_low_r;

	assign brownout_rise   = brownout_s && !brownout_prev_r;
	// Split by reset domain so each flop has a single driving process
	assign o_power_control = {pwr_high_r, pwr_brownout_r, pwr_power_on_r, pwr_low_r};

	// Only the supply reset touches these flags, so ordinary resets leave them alone
	always_ff @(posedge i_clk_sys or posedge i_supply_reset) begin
		if (i_supply_reset) begin
			brownout_prev_r <= 1'b0;
			pwr_power_on_r  <= 1'b1;
			pwr_brownout_r  <= 1'b1;
		end else begin
			brownout_prev_r <= brownout_s;
			pwr_power_on_r  <= wr_power ? i_wdata[PWR_POWER_ON] : pwr_power_on_r;
			// Hardware set wins over a software write of zero
			pwr_brownout_r  <= brownout_rise ||
				(wr_power ? i_wdata[PWR_BROWNOUT] : pwr_brownout_r);
		end
	end

	// Upper bits hold their value across reset
	always_ff @(posedge i_clk_sys) begin
		if (wr_power) begin
			pwr_high_r <= i_wdata[7:6];
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			pwr_low_r <= PWR_LOW_RESET;
		end else if (wr_power) begin
			pwr_low_r <= i_wdata[3:0];
		end
	end

	// Watchdog control and feed
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_watchdog_control <= ZERO_BYTE;
			o_watchdog_feed    <= 1'b0;
		end else begin
			o_watchdog_feed <= wr_wd_feed;
			if (reset_load_r) begin
				if (wd_cause_s) begin
					o_watchdog_control <= WD_CTRL_AFTER_WD_RESET;
				end else if (wd_enabled_s) begin
					o_watchdog_control <= WD_CTRL_ENABLED;
				end else begin
					o_watchdog_control <= WD_CTRL_DISABLED;
				end
			end else if (wr_wd_ctrl) begin
				o_watchdog_control <= i_wdata & MASK_WD_CTRL;
			end
		end
	end

	// Serial buffer carries no reset
	logic [7:0] serial_buffer_r;

	always_ff @(posedge i_clk_sys) begin
		if (wr_serbuf) begin
			serial_buffer_r <= i_wdata;
		end
	end

	// Two-wire: writes become commands, control and data reads show live status
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_tw_cmd.command         <= ZERO_BYTE;
			o_tw_cmd.command_strobe  <= 1'b0;
			o_tw_cmd.transmit_bit    <= 1'b0;
			o_tw_cmd.transmit_strobe <= 1'b0;
			o_tw_cmd.clear_timer_irq <= 1'b0;
			o_tw_cmd.config_bits     <= TW_CFG_RESET;
		end else begin
			o_tw_cmd.command_strobe  <= wr_tw_ctrl;
			o_tw_cmd.transmit_strobe <= wr_tw_data;
			o_tw_cmd.clear_timer_irq <= wr_tw_cfg && i_wdata[TW_CFG_CLR_TI];
			if (wr_tw_ctrl) begin
				o_tw_cmd.command <= i_wdata;
			end
			if (wr_tw_data) begin
				o_tw_cmd.transmit_bit <= i_wdata[TW_DAT_BIT];
			end
			if (wr_tw_cfg) begin
				o_tw_cmd.config_bits <= i_wdata & MASK_TW_CFG;
			end
		end
	end

	// Events into the interrupt block
	logic       attn_prev_r;
	logic       ready_prev_r;
	logic [EVENT_W-1:0] events;
	logic [EVENT_W-1:0] evt_status;
	logic [EVENT_W-1:0] evt_mask;

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			attn_prev_r  <= 1'b0;
			ready_prev_r <= 1'b0;
		end else begin
			attn_prev_r  <= i_tw_status.attention;
			ready_prev_r <= i_tw_status.data_ready;
		end
	end

	always_comb begin
		events               = '0;
		events[EVT_BROWNOUT] = brownout_rise;
		events[EVT_TW_ATTN]  = i_tw_status.attention && !attn_prev_r;
		events[EVT_TW_READY] = i_tw_status.data_ready && !ready_prev_r;
	end

	sfrm_irq #(
		.WIDTH (EVENT_W)
	) u_irq (
		.i_clk_sys   (i_clk_sys),
		.i_reset     (i_reset),
		.i_event     (events),
		.i_wr_status (wr_evt_status),
		.i_wr_mask   (wr_evt_mask),
		.i_wdata     (i_wdata[EVENT_W-1:0]),
		.o_status    (evt_status),
		.o_mask      (evt_mask),
		.o_irq       (o_irq)
	);

	// Read path
	logic [7:0] rd_mux;
	logic [7:0] evt_status_byte;
	logic [7:0] evt_mask_byte;

	assign evt_status_byte = {{(DATA_W-EVENT_W){1'b0}}, evt_status};
	assign evt_mask_byte   = {{(DATA_W-EVENT_W){1'b0}}, evt_mask};

	always_comb begin
		rd_mux = ZERO_BYTE;
		// Unmapped addresses read as zero
		for (int k = 0; k < PLAIN_N; k++) begin
			if (i_addr == plain_field(PLAIN_ADDR, k)) begin
				rd_mux = plain_r[k];
			end
		end
		case (i_addr)
			ADDR_PORT0:      rd_mux = o_port.port0_latch;
			ADDR_PORT1:      rd_mux = o_port.port1_latch;
			ADDR_PORT2:      rd_mux = o_port.port2_latch;
			ADDR_POWER:      rd_mux = o_power_control;
			ADDR_SERBUF:     rd_mux = serial_buffer_r;
			ADDR_WD_CTRL:    rd_mux = o_watchdog_control;
			// Clear-timer bit is write-only, so it reads zero
			ADDR_TW_CFG:     rd_mux = o_tw_cmd.config_bits;
			ADDR_TW_CTRL:    rd_mux = {i_tw_status.received_bit, i_tw_status.attention,
				i_tw_status.data_ready, i_tw_status.arb_lost, i_tw_status.start_seen,
				i_tw_status.stop_seen, i_tw_status.master, 1'b0};
			ADDR_TW_DATA:    rd_mux = {i_tw_status.received_bit, 7'h00};
			ADDR_EVT_STATUS: rd_mux = evt_status_byte & MASK_EVT;
			ADDR_EVT_MASK:   rd_mux = evt_mask_byte & MASK_EVT;
			default:         rd_mux = rd_mux;
		endcase
	end

	// Data stands only in the cycle after the read strobe
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_rdata <= ZERO_BYTE;
		end else begin
			o_rdata <= i_rd ? rd_mux : ZERO_BYTE;
		end
	end

endmodule : sfrm_bank

// ===== verilog/sfrm_pkg.sv
// Package with the register map, field layouts and reset values of the register bank
package sfrm_pkg;

	localparam int          DATA_W          = 8;
	localparam int          ADDR_W          = 8;
	localparam int          EVENT_W         = 3;

	// Registers with side effects or special reset handling
	localparam logic [7:0]  ADDR_PORT0      = 8'h80;
	localparam logic [7:0]  ADDR_PORT1      = 8'h90;
	localparam logic [7:0]  ADDR_PORT2      = 8'ha0;
	localparam logic [7:0]  ADDR_POWER      = 8'h87;
	localparam logic [7:0]  ADDR_SERBUF     = 8'h99;
	localparam logic [7:0]  ADDR_WD_FEED    = 8'ha6;
	localparam logic [7:0]  ADDR_WD_CTRL    = 8'ha7;
	localparam logic [7:0]  ADDR_TW_CFG     = 8'hc8;
	localparam logic [7:0]  ADDR_TW_CTRL    = 8'hd8;
	localparam logic [7:0]  ADDR_TW_DATA    = 8'hd9;
	localparam logic [7:0]  ADDR_EVT_STATUS = 8'hfa;
	localparam logic [7:0]  ADDR_EVT_MASK   = 8'hfb;

	// Implemented bit masks; the rest read as zero and, apart from the TW_CFG_CLR_TI strobe, ignore writes
	localparam logic [7:0]  MASK_PORT2      = 8'h03;
	localparam logic [7:0]  MASK_WD_CTRL    = 8'h3f;
	localparam logic [7:0]  MASK_TW_CFG     = 8'hd3;
	localparam logic [7:0]  MASK_EVT        = 8'h07;

	// Field positions
	localparam int          PWR_BROWNOUT    = 5;
	localparam int          PWR_POWER_ON    = 4;
	localparam int          TW_CFG_CLR_TI   = 5;
	localparam int          TW_DAT_BIT      = 7;
	localparam int          EVT_BROWNOUT    = 0;
	localparam int          EVT_TW_ATTN     = 1;
	localparam int          EVT_TW_READY    = 2;

	localparam logic [3:0]  PWR_LOW_RESET   = 4'h0;
	localparam logic [7:0]  TW_CFG_RESET    = 8'h00;
	localparam logic [7:0]  ZERO_BYTE       = 8'h00;
	localparam logic [7:0]  ONES_BYTE       = 8'hff;

	// Plain read/write registers: address, reset value, implemented bits
	localparam int          PLAIN_N         = 25;
	localparam logic [PLAIN_N*8-1:0] PLAIN_ADDR = {
		8'h81, 8'h84, 8'h85, 8'h86, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d,
		8'h91, 8'h92, 8'h98, 8'ha4, 8'ha5, 8'ha8, 8'ha9, 8'hb7, 8'hb8, 8'hb9,
		8'hd0, 8'he8, 8'hf6, 8'hf7, 8'hf8};
	localparam logic [PLAIN_N*8-1:0] PLAIN_RESET = {
		8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [PLAIN_N*8-1:0] PLAIN_MASK = {
		8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'hd3, 8'hd3, 8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'h7f, 8'h7f, 8'hff,
		8'hff, 8'hb7, 8'hff, 8'hb7, 8'hb7};
	// Index 0 is the leftmost entry above
	localparam int          IDX_P0_MODE_A   = 1;
	localparam int          IDX_P0_MODE_B   = 2;
	localparam int          IDX_P1_MODE_A   = 10;
	localparam int          IDX_P1_MODE_B   = 11;
	localparam int          IDX_P2_MODE_A   = 13;
	localparam int          IDX_P2_MODE_B   = 14;

	typedef struct packed {
		logic [7:0] port0_latch;
		logic [7:0] port1_latch;
		logic [7:0] port2_latch;
		logic [7:0] port0_mode_a;
		logic [7:0] port0_mode_b;
		logic [7:0] port1_mode_a;
		logic [7:0] port1_mode_b;
		logic [7:0] port2_mode_a;
		logic [7:0] port2_mode_b;
	} sfrm_port_type;

	typedef struct packed {
		logic received_bit;
		logic attention;
		logic data_ready;
		logic arb_lost;
		logic start_seen;
		logic stop_seen;
		logic master;
	} sfrm_tw_status_type;

	typedef struct packed {
		logic [7:0] command;
		logic       command_strobe;
		logic       transmit_bit;
		logic       transmit_strobe;
		logic       clear_timer_irq;
		logic [7:0] config_bits;
	} sfrm_tw_cmd_type;

endpackage : sfrm_pkg

// ===== verilog/sfrm_sync.sv
// Two-flop synchroniser for pin levels, without reset so it keeps sampling through reset
`timescale 1ns/100ps
module sfrm_sync
	import sfrm_pkg::*;
#(
	parameter int WIDTH = 4
) (
	input  wire logic             i_clk_sys,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_r;

	initial begin
		if (WIDTH < 1) $error("sfrm_sync: WIDTH must be at least 1");
	end

	// No reset: reset-cause and strap levels must be valid at the release edge
	always_ff @(posedge i_clk_sys) begin
		meta_r <= i_async;
		o_sync <= meta_r;
	end

endmodule : sfrm_sync

// ===== verilog/sfrm_irq.sv
// Sticky event status, mask and level interrupt
`timescale 1ns/100ps
module sfrm_irq
	import sfrm_pkg::*;
#(
	parameter int WIDTH = EVENT_W
) (
	input  wire logic             i_clk_sys,
	input  wire logic             i_reset,
	input  wire logic [WIDTH-1:0] i_event,
	input  wire logic             i_wr_status,
	input  wire logic             i_wr_mask,
	input  wire logic [WIDTH-1:0] i_wdata,
	output logic      [WIDTH-1:0] o_status,
	output logic      [WIDTH-1:0] o_mask,
	output logic                  o_irq
);
	logic [WIDTH-1:0] status_nxt;

	initial begin
		if (WIDTH < 1 || WIDTH > DATA_W) $error("sfrm_irq: WIDTH out of range");
	end

	// Set wins over a write-one clear in the same cycle
	always_comb begin
		status_nxt = (o_status & ~(i_wr_status ? i_wdata : '0)) | i_event;
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_status <= '0;
			o_mask   <= '0;
			o_irq    <= 1'b0;
		end else begin
			o_status <= status_nxt;
			if (i_wr_mask) begin
				o_mask <= i_wdata;
			end
			o_irq <= |(status_nxt & (i_wr_mask ? i_wdata : o_mask));
		end
	end

endmodule : sfrm_irq

// ===== bench/sfrm_bank_monitor.sv
// Port-level checker for the special function register bank
`timescale 1ns/100ps
module sfrm_bank_monitor
	import sfrm_pkg::*;
#(
	parameter logic [7:0] WD_CTRL_AFTER_WD_RESET = 8'h30,
	parameter logic [7:0] WD_CTRL_ENABLED        = 8'h10,
	parameter logic [7:0] WD_CTRL_DISABLED       = 8'h00
) (
	input wire logic               i_clk_sys,
	input wire logic               i_reset,
	input wire logic               i_supply_reset,
	input wire logic [ADDR_W-1:0]  i_addr,
	input wire logic [DATA_W-1:0]  i_wdata,
	input wire logic               i_wr,
	input wire logic               i_rd,
	input wire logic [DATA_W-1:0]  o_rdata,
	input wire logic               i_watchdog_reset_cause,
	input wire logic               i_watchdog_enabled,
	input wire logic               i_port_reset_level_select,
	input wire sfrm_tw_status_type i_tw_status,
	input wire sfrm_tw_cmd_type    o_tw_cmd,
	input wire sfrm_port_type      o_port,
	input wire logic [7:0]         o_power_control,
	input wire logic [7:0]         o_watchdog_control,
	input wire logic               o_irq
);
	logic [1:0] flags_r;
	logic [7:0] wd_exp;
	// Flags as reset rises; a supply reset may overwrite them, so that case is skipped below
	always_ff @(posedge i_reset) flags_r <= o_power_control[5:4];
	assign wd_exp = (i_watchdog_reset_cause ? WD_CTRL_AFTER_WD_RESET :
		(i_watchdog_enabled ? WD_CTRL_ENABLED : WD_CTRL_DISABLED)) & MASK_WD_CTRL;
	default clocking mon_cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_reset);
	AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == ZERO_BYTE)
		else $error("read data not zero outside a read answer");
	AST_TW_STATUS: assert property (i_rd && i_addr == ADDR_TW_CTRL |=>
		o_rdata == {$past(i_tw_status), 1'b0}) else $error("two-wire status read wrong");
	AST_TW_RXBIT: assert property (i_rd && i_addr == ADDR_TW_DATA |=>
		o_rdata == {$past(i_tw_status.received_bit), 7'h00}) else $error("data read wrong");
	AST_TW_CMD: assert property (i_wr && i_addr == ADDR_TW_CTRL |=> o_tw_cmd.command_strobe
		&& o_tw_cmd.command == $past(i_wdata)) else $error("command write wrong");
	AST_CMD_CAUSE: assert property (o_tw_cmd.command_strobe |-> $past(i_wr)
		&& $past(i_addr) == ADDR_TW_CTRL) else $error("command strobe without write");
	AST_TX_BIT: assert property (i_wr && i_addr == ADDR_TW_DATA |=> o_tw_cmd.transmit_strobe
		&& o_tw_cmd.transmit_bit == $past(i_wdata[7])) else $error("transmit bit wrong");
	AST_CLR_TI: assert property (i_wr && i_addr == ADDR_TW_CFG |=>
		o_tw_cmd.clear_timer_irq == $past(i_wdata[5])) else $error("timer clear pulse wrong");
	AST_PORT_RESET: assert property ($fell(i_reset) |=>
		o_port.port0_latch == {8{i_port_reset_level_select}}
		&& o_port.port2_latch == ({8{i_port_reset_level_select}} & MASK_PORT2))
		else $error("port latch reset level wrong");
	AST_WD_RESET: assert property ($fell(i_reset) |=> o_watchdog_control == wd_exp)
		else $error("watchdog control reset value wrong");
	AST_PWR_LOW: assert property ($fell(i_reset) |-> o_power_control[3:0] == PWR_LOW_RESET)
		else $error("power control low bits not cleared");
	AST_FLAGS_KEPT: assert property ($fell(i_reset) && !$past(i_supply_reset) |->
		o_power_control[5:4] == flags_r) else $error("power flags lost over reset");
	COV_RESET: cover property ($fell(i_reset));
	COV_TW_READ: cover property (i_rd && i_addr == ADDR_TW_CTRL);
	COV_IRQ: cover property ($fell(o_irq));
endmodule : sfrm_bank_monitor

bind sfrm_bank sfrm_bank_monitor #(.WD_CTRL_AFTER_WD_RESET(WD_CTRL_AFTER_WD_RESET),
	.WD_CTRL_ENABLED(WD_CTRL_ENABLED), .WD_CTRL_DISABLED(WD_CTRL_DISABLED)) i_mon (
	.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_supply_reset(i_supply_reset),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_watchdog_reset_cause(i_watchdog_reset_cause), .i_watchdog_enabled(i_watchdog_enabled),
	.i_port_reset_level_select(i_port_reset_level_select), .i_tw_status(i_tw_status),
	.o_tw_cmd(o_tw_cmd), .o_port(o_port), .o_power_control(o_power_control),
	.o_watchdog_control(o_watchdog_control), .o_irq(o_irq));

// ===== bench/test_sfrm_bank.sv
// Self-checking bench for the special function register bank
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin \
	$display("unexpected at %0t: got %h expected %h", $time, a, b); num_errors++; end end
module test_sfrm_bank
	import sfrm_pkg::*;
();
	localparam logic [7:0] WD_A = 8'h30;
	localparam logic [7:0] WD_E = 8'h10;
	localparam logic [7:0] WD_D = 8'h00;
	logic clk, rst, sup, wr, rd, bo, cause, en, sel, irq, feed, a_irq, b_irq;
	logic [7:0]         addr, wdata, rdata, pwr, wdc, d, v;
	sfrm_tw_status_type tw;
	sfrm_tw_cmd_type    cmd;
	sfrm_port_type      port;
	int                 num_errors, n_tests, i;

	sfrm_bank #(.WD_CTRL_AFTER_WD_RESET(WD_A), .WD_CTRL_ENABLED(WD_E),
		.WD_CTRL_DISABLED(WD_D)) i_dut (
		.i_clk_sys(clk), .i_reset(rst), .i_supply_reset(sup), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_brownout_event(bo),
		.i_watchdog_reset_cause(cause), .i_watchdog_enabled(en),
		.i_port_reset_level_select(sel), .i_tw_status(tw), .o_tw_cmd(cmd), .o_port(port),
		.o_power_control(pwr), .o_watchdog_control(wdc), .o_watchdog_feed(feed),
		.o_irq(irq));

	function automatic logic [7:0] tbl(input logic [PLAIN_N*8-1:0] t, input int k);
		return t[(PLAIN_N-1-k)*8 +: 8];
	endfunction : tbl

	function automatic logic [7:0] wd_exp(input logic c, input logic e);
		return (c ? WD_A : (e ? WD_E : WD_D)) & MASK_WD_CTRL;
	endfunction : wd_exp

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= x;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] x);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 x = rdata;
	endtask : rd_reg

	// Config pins settle before release because the synchroniser has no reset
	task automatic do_reset(input logic l, input logic c, input logic e);
		@(posedge clk);
		sel <= l;
		cause <= c;
		en <= e;
		repeat (3) @(posedge clk);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask : do_reset

	task automatic check_all(input logic l, input logic c, input logic e);
		logic [7:0] x;
		rd_reg(ADDR_PORT0, x);
		`CHK(x, {8{l}})
		rd_reg(ADDR_PORT1, x);
		`CHK(x, {8{l}})
		rd_reg(ADDR_PORT2, x);
		`CHK(x, {8{l}} & MASK_PORT2)
		rd_reg(ADDR_WD_CTRL, x);
		`CHK(x, wd_exp(c, e))
		for (int k = 0; k < PLAIN_N; k++) begin
			rd_reg(tbl(PLAIN_ADDR, k), x);
			`CHK(x, tbl(PLAIN_RESET, k))
		end
	endtask : check_all

	task automatic conclude();
		$display("errors %0d, checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		#100000;
		num_errors++;
		conclude();
	end

	initial begin
		{rst, sup, wr, rd, bo, cause, en, sel} = 8'hc3;
		{addr, wdata, tw} = '0;
		num_errors = 0;
		n_tests = 0;
		void'($urandom(34));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		sup <= 1'b0;
		@(posedge clk);
		check_all(1'b1, 1'b0, 1'b1);
		rd_reg(ADDR_POWER, d);
		`CHK(d[5:4], 2'b11)
		`CHK(d[3:0], PWR_LOW_RESET)
		// Odd entries also hit unimplemented bits on purpose
		for (i = 0; i < PLAIN_N; i++) begin
			v = $urandom;
			if (i % 2 == 0) begin
				v &= tbl(PLAIN_MASK, i);
			end
			wr_reg(tbl(PLAIN_ADDR, i), v);
			rd_reg(tbl(PLAIN_ADDR, i), d);
			`CHK(d, v & tbl(PLAIN_MASK, i))
			if (i == IDX_P0_MODE_A) begin
				`CHK(port.port0_mode_a, v & tbl(PLAIN_MASK, i))
			end
			if (i == IDX_P2_MODE_B) begin
				`CHK(port.port2_mode_b, v & tbl(PLAIN_MASK, i))
			end
		end
		wr_reg(ADDR_PORT2, ONES_BYTE);
		rd_reg(ADDR_PORT2, d);
		`CHK(d, MASK_PORT2)
		rd_reg(8'h82, d);
		`CHK(d, ZERO_BYTE)
		wr_reg(ADDR_WD_FEED, v);
		#1 `CHK(feed, 1'b1)
		@(posedge clk);
		#1 `CHK(feed, 1'b0)
		for (i = 0; i < 8; i++) begin
			@(posedge clk);
			tw <= $urandom;
			v = $urandom;
			rd_reg(ADDR_TW_CTRL, d);
			`CHK(d, {tw, 1'b0})
			rd_reg(ADDR_TW_DATA, d);
			`CHK(d, {tw.received_bit, 7'h00})
			wr_reg(ADDR_TW_CTRL, v);
			#1 `CHK(cmd.command, v)
			wr_reg(ADDR_TW_DATA, v);
			#1 `CHK(cmd.transmit_bit, v[TW_DAT_BIT])
			wr_reg(ADDR_TW_CFG, v);
			#1 `CHK(cmd.clear_timer_irq, v[TW_CFG_CLR_TI])
			rd_reg(ADDR_TW_CFG, d);
			`CHK(d, v & MASK_TW_CFG)
		end
		@(posedge clk);
		tw <= '0;
		wr_reg(ADDR_EVT_STATUS, MASK_EVT);
		wr_reg(ADDR_POWER, 8'h0c);
		rd_reg(ADDR_POWER, d);
		`CHK(d, 8'h0c)
		@(posedge clk);
		bo <= 1'b1;
		repeat (4) @(posedge clk);
		bo <= 1'b0;
		rd_reg(ADDR_POWER, d);
		`CHK(d, 8'h2c)
		rd_reg(ADDR_EVT_STATUS, d);
		`CHK(d, 8'h01)
		// The check accepts either mask polarity, so exactly one of the two settings must raise the line
		wr_reg(ADDR_EVT_MASK, ZERO_BYTE);
		repeat (2) @(posedge clk);
		#1 a_irq = irq;
		wr_reg(ADDR_EVT_MASK, MASK_EVT);
		repeat (2) @(posedge clk);
		#1 b_irq = irq;
		`CHK(a_irq ^ b_irq, 1'b1)
		wr_reg(ADDR_EVT_MASK, a_irq ? ZERO_BYTE : MASK_EVT);
		wr_reg(ADDR_EVT_STATUS, MASK_EVT);
		repeat (2) @(posedge clk);
		#1 `CHK(irq, 1'b0)
		v = $urandom | 32'h1;
		wr_reg(ADDR_SERBUF, v);
		do_reset(1'b0, 1'b1, 1'b0);
		check_all(1'b0, 1'b1, 1'b0);
		rd_reg(ADDR_POWER, d);
		`CHK(d, 8'h20)
		rd_reg(ADDR_SERBUF, d);
		`CHK(d, v)
		do_reset(1'b1, 1'b0, 1'b0);
		check_all(1'b1, 1'b0, 1'b0);
		conclude();
	end
endmodule : test_sfrm_bank
